/* File: verilog/i2ccc_consts.svh */
`ifndef I2CCC_CONSTS_SVH
`define I2CCC_CONSTS_SVH
// register indices; byte address is four times the index
`define I2CCC_IDX_CNT0 10'h240
`define I2CCC_IDX_XFR0 10'h241
`define I2CCC_IDX_EN0 10'h247
`define I2CCC_IDX_CNT1 10'h248
`define I2CCC_IDX_XFR1 10'h249
`define I2CCC_IDX_EN1 10'h24f
// field positions
`define I2CCC_EN_BIT 7
`define I2CCC_BC_HI 7
`define I2CCC_BC_LO 5
`define I2CCC_ACK_BIT 4
`define I2CCC_SCK_HI 2
`define I2CCC_SCK_LO 0
`define I2CCC_MON_BIT 0
`define I2CCC_GO_BIT 0
`define I2CCC_SRST_BIT 1
`define I2CCC_BUSY_BIT 0
`define I2CCC_SCLLV_BIT 2
`define I2CCC_SDALV_BIT 3
// reset values and codes
`define I2CCC_BC_RST 3'h0
`define I2CCC_SCK_RST 3'h0
`define I2CCC_BC_FULL 3'h0
`define I2CCC_FULL_BITS 4'h8
`define I2CCC_FULL_ACK 4'h9
`define I2CCC_N_BASE 4'h4
`define I2CCC_SCL_ADD 11'h024
`define I2CCC_SCK_RSVD 3'h7
`define I2CCC_SCK_MAX 3'h6
`define I2CCC_SRST_CYC 3'h4
`define I2CCC_RESP_OK 2'h0
`define I2CCC_RESP_ERR 2'h2
`endif

/* File: verilog/i2ccc_pkg.sv */
`include "i2ccc_consts.svh"
package i2ccc_pkg;
  typedef enum logic [1:0] {k_none, k_cnt, k_en, k_xfr} i2ccc_kind_e;
  typedef enum logic [1:0] {scl_idle, scl_low, scl_high} i2ccc_scl_e;

  typedef struct packed {
    logic scl_m, scl_s, sda_m, sda_s;
    i2ccc_scl_e st;
    logic [10:0] cnt;
    logic [3:0] pulses;
    logic [2:0] srst_cnt;
    logic scl_o, scl_oe, busy, srst_busy, scl_lv, sda_lv;
  } i2ccc_ch_s;

  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic have_aw, have_w, w_lane;
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic [1:0] en, ack, go, srst;
    logic [1:0][2:0] bc, sck;
    i2ccc_kind_e rd_kind;
    logic rd_ch;
  } i2ccc_top_s;

  function automatic i2ccc_kind_e i2ccc_kind(input logic [11:0] a);
    if (a[1:0] != 2'h0) return k_none;
    case (a[11:2])
      `I2CCC_IDX_CNT0, `I2CCC_IDX_CNT1: return k_cnt;
      `I2CCC_IDX_EN0, `I2CCC_IDX_EN1: return k_en;
      `I2CCC_IDX_XFR0, `I2CCC_IDX_XFR1: return k_xfr;
      default: return k_none;
    endcase
  endfunction

  // channel 1 indices sit 8 above channel 0
  function automatic logic i2ccc_ch(input logic [11:0] a);
    return a[5];
  endfunction

  function automatic logic [3:0] i2ccc_pulses(input logic [2:0] bc,
                                              input logic ack);
    logic [3:0] b;
    b = (bc == `I2CCC_BC_FULL) ? `I2CCC_FULL_BITS : {1'b0, bc};
    return b + {3'h0, ack};
  endfunction

  // half scl period in system clocks: 2^(n+4) + 36
  function automatic logic [10:0] i2ccc_half(input logic [2:0] sck);
    logic [3:0] s;
    s = (sck == `I2CCC_SCK_RSVD) ? {1'b0, `I2CCC_SCK_MAX} : {1'b0, sck};
    return (11'h001 << (s + `I2CCC_N_BASE)) + `I2CCC_SCL_ADD;
  endfunction
endpackage

/* File: verilog/i2ccc_chan.sv */
`timescale 1ns/10ps
`include "i2ccc_consts.svh"
module i2ccc_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic enable,
  input wire logic [2:0] transfer_bit_count,
  input wire logic ack_clk,
  input wire logic [2:0] scl_rate_select,
  input wire logic go,
  input wire logic srst_req,
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  // status
  output logic busy,
  output logic srst_busy,
  output logic scl_lv,
  output logic sda_lv
);
  import i2ccc_pkg::*;

  i2ccc_ch_s q_ff, nxt_q;
  logic [10:0] half;

  assign half = i2ccc_half(scl_rate_select) - 11'h001;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.scl_m = scl_i;
    nxt_q.scl_s = q_ff.scl_m;
    nxt_q.sda_m = sda_i;
    nxt_q.sda_s = q_ff.sda_m;
    nxt_q.scl_lv = q_ff.scl_s;
    nxt_q.sda_lv = q_ff.sda_s;
    nxt_q.scl_o = 1'b0;
    if (q_ff.srst_cnt != 3'h0) begin
      nxt_q.srst_cnt = q_ff.srst_cnt - 3'h1;
    end
    if (!enable || srst_req) begin
      nxt_q.st = scl_idle;
      nxt_q.scl_oe = 1'b0;
      if (srst_req) begin
        nxt_q.srst_cnt = `I2CCC_SRST_CYC;
      end
    end else begin
      case (q_ff.st)
        scl_idle: begin
          if (go && q_ff.srst_cnt == 3'h0) begin
            nxt_q.pulses = i2ccc_pulses(transfer_bit_count, ack_clk);
            nxt_q.cnt = half;
            nxt_q.st = scl_low;
            nxt_q.scl_oe = 1'b1;
          end
        end
        scl_low: begin
          if (q_ff.cnt == 11'h000) begin
            nxt_q.scl_oe = 1'b0;
            nxt_q.cnt = half;
            nxt_q.st = scl_high;
          end else begin
            nxt_q.cnt = q_ff.cnt - 11'h001;
          end
        end
        scl_high: begin
          // a held-low line means a slave stretches: wait it out
          if (q_ff.cnt != 11'h000) begin
            nxt_q.cnt = q_ff.cnt - 11'h001;
          end else if (q_ff.scl_s) begin
            if (q_ff.pulses == 4'h1) begin
              nxt_q.st = scl_idle;
            end else begin
              nxt_q.pulses = q_ff.pulses - 4'h1;
              nxt_q.cnt = half;
              nxt_q.st = scl_low;
              nxt_q.scl_oe = 1'b1;
            end
          end
        end
        default: begin
          nxt_q.st = scl_idle;
          nxt_q.scl_oe = 1'b0;
        end
      endcase
    end
    nxt_q.busy = (nxt_q.st != scl_idle);
    nxt_q.srst_busy = (nxt_q.srst_cnt != 3'h0);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign scl_o = q_ff.scl_o;
  assign scl_oe = q_ff.scl_oe;
  assign busy = q_ff.busy;
  assign srst_busy = q_ff.srst_busy;
  assign scl_lv = q_ff.scl_lv;
  assign sda_lv = q_ff.sda_lv;
endmodule

/* File: verilog/i2ccc_top.sv */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "i2ccc_consts.svh"
module i2ccc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // i2c lines, index is channel
  input wire logic [1:0] scl_i,
  output logic [1:0] scl_o,
  output logic [1:0] scl_oe,
  input wire logic [1:0] sda_i
);
  import i2ccc_pkg::*;

  i2ccc_top_s q_ff, nxt_q;
  logic [1:0] busy;
  logic [1:0] srst_busy;
  logic [1:0] scl_lv;
  logic [1:0] sda_lv;

  ////////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar c = 0; c < 2; c++) begin : g_ch
    i2ccc_chan u_chan (
      .clk(clk),
      .rst_b(rst_b),
      .enable(q_ff.en[c]),
      .transfer_bit_count(q_ff.bc[c]),
      .ack_clk(q_ff.ack[c]),
      .scl_rate_select(q_ff.sck[c]),
      .go(q_ff.go[c]),
      .srst_req(q_ff.srst[c]),
      .scl_i(scl_i[c]),
      .sda_i(sda_i[c]),
      .scl_o(scl_o[c]),
      .scl_oe(scl_oe[c]),
      .busy(busy[c]),
      .srst_busy(srst_busy[c]),
      .scl_lv(scl_lv[c]),
      .sda_lv(sda_lv[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic aw_take, w_take, ar_take, have_a, have_d;
  logic [11:0] wa;
  logic [7:0] wb;
  logic wl, wc, rc;
  i2ccc_kind_e wk, rk;
  logic [7:0] rbyte;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.go = 2'h0;
    nxt_q.srst = 2'h0;
    aw_take = s_axi_awvalid && q_ff.awready;
    w_take = s_axi_wvalid && q_ff.wready;
    ar_take = s_axi_arvalid && q_ff.arready;
    have_a = q_ff.have_aw || aw_take;
    have_d = q_ff.have_w || w_take;
    wa = q_ff.have_aw ? q_ff.aw_addr : s_axi_awaddr;
    wb = q_ff.have_w ? q_ff.w_byte : s_axi_wdata[7:0];
    wl = q_ff.have_w ? q_ff.w_lane : s_axi_wstrb[0];
    wk = i2ccc_kind(wa);
    wc = i2ccc_ch(wa);
    rk = i2ccc_kind(s_axi_araddr);
    rc = i2ccc_ch(s_axi_araddr);
    rbyte = 8'h00;
    if (q_ff.bvalid && s_axi_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    if (aw_take) begin
      nxt_q.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_q.w_byte = s_axi_wdata[7:0];
      nxt_q.w_lane = s_axi_wstrb[0];
    end
    // address and data may come in either order; the early one waits
    // in its holding register until its partner shows up
    if (have_a && have_d) begin
      nxt_q.have_aw = 1'b0;
      nxt_q.have_w = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = (wk == k_none) ? `I2CCC_RESP_ERR : `I2CCC_RESP_OK;
      // only the low lane holds a register; other lanes are dropped
      if (wl) begin
        case (wk)
          k_en: begin
            nxt_q.en[wc] = wb[`I2CCC_EN_BIT];
          end
          k_cnt: begin
            // channel must be on before it takes configuration
            if (q_ff.en[wc]) begin
              nxt_q.bc[wc] = wb[`I2CCC_BC_HI:`I2CCC_BC_LO];
              nxt_q.ack[wc] = wb[`I2CCC_ACK_BIT];
              nxt_q.sck[wc] = wb[`I2CCC_SCK_HI:`I2CCC_SCK_LO];
            end
          end
          k_xfr: begin
            if (q_ff.en[wc]) begin
              nxt_q.go[wc] = wb[`I2CCC_GO_BIT];
              if (wb[`I2CCC_SRST_BIT]) begin
                nxt_q.srst[wc] = 1'b1;
                nxt_q.go[wc] = 1'b0;
                nxt_q.bc[wc] = `I2CCC_BC_RST;
                nxt_q.ack[wc] = 1'b0;
                nxt_q.sck[wc] = `I2CCC_SCK_RST;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      nxt_q.have_aw = have_a;
      nxt_q.have_w = have_d;
    end
    nxt_q.awready = !nxt_q.have_aw && !nxt_q.bvalid;
    nxt_q.wready = !nxt_q.have_w && !nxt_q.bvalid;

    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
    end
    // status is frozen at the take edge, so busy may lag one cycle
    if (ar_take) begin
      case (rk)
        k_en: begin
          rbyte[`I2CCC_EN_BIT] = q_ff.en[rc];
        end
        k_cnt: begin
          // count field and rate bits 2:1 are write-only and read as zero; bit 0 is the monitor
          rbyte[`I2CCC_ACK_BIT] = q_ff.ack[rc];
          rbyte[`I2CCC_MON_BIT] = !srst_busy[rc];
        end
        k_xfr: begin
          rbyte[`I2CCC_BUSY_BIT] = busy[rc];
          rbyte[`I2CCC_SCLLV_BIT] = scl_lv[rc];
          rbyte[`I2CCC_SDALV_BIT] = sda_lv[rc];
        end
        default: begin
        end
      endcase
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = {24'h000000, rbyte};
      nxt_q.rresp = (rk == k_none) ? `I2CCC_RESP_ERR : `I2CCC_RESP_OK;
      nxt_q.rd_kind = rk;
      nxt_q.rd_ch = rc;
    end
    nxt_q.arready = !nxt_q.rvalid;
  end

  // every control reset value is zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_awready = q_ff.awready;
  assign s_axi_wready = q_ff.wready;
  assign s_axi_bvalid = q_ff.bvalid;
  assign s_axi_bresp = q_ff.bresp;
  assign s_axi_arready = q_ff.arready;
  assign s_axi_rvalid = q_ff.rvalid;
  assign s_axi_rdata = q_ff.rdata;
  assign s_axi_rresp = q_ff.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // helper counters: cycles of each low phase, pulses per burst
  logic [1:0] oe_d_ff;
  logic [1:0][10:0] low_len_ff;
  logic [1:0][3:0] pcnt_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_d_ff <= 2'h0;
      low_len_ff <= '0;
      pcnt_ff <= '0;
    end else begin
      oe_d_ff <= scl_oe;
      for (int c = 0; c < 2; c++) begin
        low_len_ff[c] <= scl_oe[c] ? low_len_ff[c] + 11'h001 : 11'h000;
        if (!busy[c]) begin
          pcnt_ff[c] <= 4'h0;
        end else if (scl_oe[c] && !oe_d_ff[c]) begin
          pcnt_ff[c] <= pcnt_ff[c] + 4'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not one cycle after both taken");

  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");

  resp_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  en_read_a: assert property (
    $rose(s_axi_rvalid) && q_ff.rd_kind == k_en
    |-> s_axi_rdata[6:0] == 7'h00 && s_axi_rdata[31:8] == 24'h000000)
    else $error("enable register low bits not zero");

  mon_read_a: assert property (
    $rose(s_axi_rvalid) && q_ff.rd_kind == k_cnt && !q_ff.rd_ch
    |-> s_axi_rdata[0] == !$past(srst_busy[0]) &&
        s_axi_rdata[7:5] == 3'h0)
    else $error("soft reset monitor read wrong");

  for (genvar c = 0; c < 2; c++) begin : g_chk
    off_idle_a: assert property (
      !q_ff.en[c] |=> !scl_oe[c] && !busy[c])
      else $error("disabled channel still drives scl");

    indep_a: assert property (
      q_ff.go[c] && !q_ff.go[1-c] && !busy[1-c] |=> !busy[1-c])
      else $error("start on one channel moved the other");

    pulse_cnt_a: assert property (
      $fell(busy[c]) && $past(q_ff.en[c]) && !$past(q_ff.srst[c])
      |-> pcnt_ff[c] == i2ccc_pulses(q_ff.bc[c], q_ff.ack[c]))
      else $error("wrong number of scl pulses");

    ack9_a: assert property (
      $fell(busy[c]) && $past(q_ff.en[c]) && !$past(q_ff.srst[c]) &&
      q_ff.bc[c] == `I2CCC_BC_FULL && q_ff.ack[c]
      |-> pcnt_ff[c] == `I2CCC_FULL_ACK)
      else $error("full byte with ack not nine pulses");

    low_len_a: assert property (
      $fell(scl_oe[c]) && busy[c]
      |-> low_len_ff[c] == i2ccc_half(q_ff.sck[c]))
      else $error("scl low phase length wrong");

    rsvd_a: assert property (
      $fell(scl_oe[c]) && busy[c] && q_ff.sck[c] == `I2CCC_SCK_RSVD
      |-> low_len_ff[c] == i2ccc_half(`I2CCC_SCK_MAX))
      else $error("reserved rate code not held at slowest");

    srst_mon_a: assert property (
      q_ff.srst[c] |=> srst_busy[c] [*4] ##1 !srst_busy[c])
      else $error("soft reset monitor window wrong");

    // scl is only pulled low inside a burst
    oe_busy_a: assert property (
      scl_oe[c] |-> busy[c])
      else $error("scl driven outside a burst");

    srst_abort_a: assert property (
      q_ff.srst[c] |=> !scl_oe[c] && !busy[c])
      else $error("soft reset did not stop the burst");

    // a disabled channel must not pick up stray configuration
    cfg_locked_a: assert property (
      !q_ff.en[c] |=> $stable(q_ff.bc[c]) && $stable(q_ff.sck[c]) &&
                      $stable(q_ff.ack[c]))
      else $error("configuration changed while disabled");

    go_gate_a: assert property (
      q_ff.go[c] |-> q_ff.en[c])
      else $error("start strobe on a disabled channel");

    pcnt_cap_a: assert property (
      busy[c] |-> pcnt_ff[c] <= `I2CCC_FULL_ACK)
      else $error("more than nine pulses in one burst");

    // both channels share one design, so each must start alike
    same_beh_a: assert property (
      q_ff.go[c] && q_ff.en[c] && !busy[c] && !srst_busy[c]
      |=> scl_oe[c] && busy[c])
      else $error("start did not open a burst");

    burst_c: cover property (
      $fell(busy[c]) && pcnt_ff[c] == `I2CCC_FULL_ACK);
    srst_c: cover property ($fell(srst_busy[c]));
  end

  scl_o_low_a: assert property (
    scl_o == 2'h0)
    else $error("open drain scl output driven high");

  // write-only count field and rate bits 2:1 read back as zero
  cnt_ro_a: assert property (
    $rose(s_axi_rvalid) && q_ff.rd_kind == k_cnt
    |-> s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[3:1] == 3'h0)
    else $error("write-only field read back");

  err_zero_a: assert property (
    $rose(s_axi_rvalid) && s_axi_rresp == `I2CCC_RESP_ERR
    |-> s_axi_rdata == 32'h00000000)
    else $error("unmapped read returned data");

  write_c: cover property (s_axi_bvalid && s_axi_bready);
  err_c: cover property (s_axi_rvalid && s_axi_rresp == `I2CCC_RESP_ERR);
  mon0_c: cover property (
    $rose(s_axi_rvalid) && q_ff.rd_kind == k_cnt && !s_axi_rdata[0]);
endmodule

/* File: bench/i2ccc_bus_peer.sv */
`timescale 1ns/10ps
module i2ccc_bus_peer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // device side
  input wire logic [1:0] scl_oe,
  input wire logic [7:0] stretch_cyc,
  // bus lines, pulled up
  output logic [1:0] scl_line,
  output logic [1:0] sda_line
);
  logic [1:0][7:0] cnt_ff;
  logic [1:0] oe_ff;
  logic [1:0] pull;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      oe_ff <= '0;
    end else begin
      oe_ff <= scl_oe;
      for (int c = 0; c < 2; c++) begin
        if (oe_ff[c] && !scl_oe[c]) begin
          cnt_ff[c] <= stretch_cyc;
        end else if (cnt_ff[c] != 8'h00) begin
          cnt_ff[c] <= cnt_ff[c] - 8'h01;
        end
      end
    end
  end
  // hold low from the very release, as a slow slave would
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pull[c] = (oe_ff[c] && !scl_oe[c]) || (cnt_ff[c] != 8'h00);
    end
  end
  assign scl_line = ~(scl_oe | pull);
  // data line released: pull-up holds it high
  assign sda_line = 2'h3;
endmodule

/* File: bench/test_i2c_clock_and_count_control.sv */
`timescale 1ns/10ps
`include "i2ccc_consts.svh"
module test_i2c_clock_and_count_control;
  import i2ccc_pkg::*;
  logic clk = 0, rst_b = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, scl_o, scl_oe, scl_line, sda_line;
  logic [7:0] stretch_cyc = '0;
  logic [33:0] wq[$], rq[$];
  logic [1:0] oe_prev = '0;
  int hi_len[2], exp_h[2], pulses[2], rel_len[2], exp_r[2];
  int bad_count = 0, tests_run = 0, seed = 59;
  always #25 clk = ~clk;
  i2ccc_top dut_u (.clk(clk), .rst_b(rst_b),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line));
  i2ccc_bus_peer peer_u (.clk(clk), .rst_b(rst_b), .scl_oe(scl_oe),
    .stretch_cyc(stretch_cyc), .scl_line(scl_line), .sda_line(sda_line));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] exp,
                       input logic [33:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus master: note the expected answer, the monitor compares it
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit aw_d, w_d;
    aw_d = 0;
    w_d = 0;
    wq.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    // full byte each time, never read-modify-write
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // ready stays up between transfers, so no double drive on one edge
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw_d && awready) begin
        aw_d = 1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    rq.push_back({er, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) begin
      check("bresp", wq.pop_front(), {bresp, 32'h0});
    end
    if (rvalid && rready) begin
      check("read", rq.pop_front(), {rresp, rdata});
    end
    for (int c = 0; c < 2; c++) begin
      if (scl_oe[c]) begin
        hi_len[c]++;
      end else if (oe_prev[c]) begin
        check("scl low phase", 34'(exp_h[c]), 34'(hi_len[c]));
        pulses[c]++;
      end
      if (!scl_oe[c]) begin
        hi_len[c] = 0;
        rel_len[c]++;
      end else if (!oe_prev[c] && pulses[c] > 0) begin
        // released span: the half period, or longer while held low
        check("scl high phase", 34'(exp_r[c]), 34'(rel_len[c]));
      end
      if (scl_oe[c]) begin
        rel_len[c] = 0;
      end
    end
    oe_prev <= scl_oe;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [9:0] idx, input bit c);
    return {idx + (c ? 10'h008 : 10'h000), 2'h0};
  endfunction
  // one burst; the wait follows from the documented half period
  task automatic xfer(input bit c, input logic [2:0] bc, input logic ack,
                      input logic [2:0] rate, input logic [7:0] st);
    int np;
    np = ((bc == 3'h0) ? 8 : int'(bc)) + int'(ack);
    // the reserved rate code runs as the slowest one
    exp_h[c] = (rate == `I2CCC_SCK_RSVD) ?
               (1 << (int'(`I2CCC_SCK_MAX) + 4)) + 36 :
               (1 << (int'(rate) + 4)) + 36;
    // a held line adds two sync flops and the decision cycle
    exp_r[c] = (exp_h[c] > int'(st) + 4) ? exp_h[c] : int'(st) + 4;
    pulses[c] = 0;
    stretch_cyc <= st;
    wr(ba(`I2CCC_IDX_CNT0, c), {bc, ack, 1'b0, rate}, `I2CCC_RESP_OK);
    rd(ba(`I2CCC_IDX_CNT0, c), {3'h0, ack, 4'h1}, `I2CCC_RESP_OK);
    wr(ba(`I2CCC_IDX_XFR0, c), 8'h01, `I2CCC_RESP_OK);
    repeat (np * (2 * exp_h[c] + int'(st) + 6) + 40) @(posedge clk);
    rd(ba(`I2CCC_IDX_XFR0, c), 8'h0c, `I2CCC_RESP_OK);
    check("pulse count", 34'(np), 34'(pulses[c]));
    $display("test burst ch %0d code %0d ack %0d done", c, bc, ack);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    logic a;
    logic [2:0] r;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ba(`I2CCC_IDX_EN0, 0), 8'h00, `I2CCC_RESP_OK);
    rd(ba(`I2CCC_IDX_CNT0, 0), 8'h01, `I2CCC_RESP_OK);
    rd(12'h908, 8'h00, `I2CCC_RESP_ERR);
    wr(12'h908, 8'h55, `I2CCC_RESP_ERR);
    wr(ba(`I2CCC_IDX_EN0, 0), 8'hff, `I2CCC_RESP_OK);
    rd(ba(`I2CCC_IDX_EN0, 0), 8'h80, `I2CCC_RESP_OK);
    // settings written before enable must not stick
    wr(ba(`I2CCC_IDX_CNT0, 1), 8'h10, `I2CCC_RESP_OK);
    wr(ba(`I2CCC_IDX_EN0, 1), 8'h80, `I2CCC_RESP_OK);
    rd(ba(`I2CCC_IDX_CNT0, 1), 8'h01, `I2CCC_RESP_OK);
    $display("test registers done");
    for (int b = 0; b < 8; b++) begin
      a = $random(seed);
      // rate codes 2 and 3 keep scl at or under standard-mode speed
      r = 3'h2 + 3'(($random(seed) & 32'h7fffffff) % 2);
      xfer(0, 3'(b), a, r, 8'h00);
    end
    xfer(1, 3'h1, 1'b0, `I2CCC_SCK_MAX, 8'h05);
    // reserved code, expected to run at the slowest rate
    xfer(1, 3'h1, 1'b0, `I2CCC_SCK_RSVD, 8'h05);
    // a long hold stretches every high phase past its half period
    xfer(1, 3'h0, 1'b1, 3'h2, 8'hc8);
    wr(ba(`I2CCC_IDX_CNT0, 0), 8'h10, `I2CCC_RESP_OK);
    wr(ba(`I2CCC_IDX_XFR0, 0), 8'h02, `I2CCC_RESP_OK);
    rd(ba(`I2CCC_IDX_CNT0, 0), 8'h00, `I2CCC_RESP_OK);
    repeat (10) @(posedge clk);
    rd(ba(`I2CCC_IDX_CNT0, 0), 8'h01, `I2CCC_RESP_OK);
    $display("test soft reset done");
    pulses[0] = 0;
    wr(ba(`I2CCC_IDX_EN0, 0), 8'h00, `I2CCC_RESP_OK);
    wr(ba(`I2CCC_IDX_XFR0, 0), 8'h01, `I2CCC_RESP_OK);
    repeat (300) @(posedge clk);
    check("pulses while off", 34'h0, 34'(pulses[0]));
    $display("test disabled start done");
    give_verdict();
  end
endmodule
